// >>> hw/cmc_map.vh
/*
 * Constant map of the operating mode control block: register offsets,
 * control field positions, reset values, mode bit positions and size codes.
 * Assumes it is included by bare name from the design files only.
 */
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define CMC_OFS_CTRL    4'h0
`define CMC_OFS_STATUS  4'h4
`define CMC_OFS_SIZES   4'h8

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define CMC_CTRL_PROT_EN  0
`define CMC_CTRL_PAGE_EN  1
`define CMC_CTRL_LONG_EN  2
`define CMC_CTRL_RESET    3'h0

// ****************************************************************
// Mode bit positions inside the one-hot mode vector
// ****************************************************************
`define CMC_M_REAL    0
`define CMC_M_PROT    1
`define CMC_M_EMUL    2
`define CMC_M_FWSVC   3
`define CMC_M_LONG64  4
`define CMC_M_COMPAT  5
`define CMC_MODE_W    6

// ****************************************************************
// Size codes for address and operand size outputs
// ****************************************************************
`define CMC_SZ_16  2'h0
`define CMC_SZ_32  2'h1
`define CMC_SZ_64  2'h2

`endif

// >>> hw/cmc_addr_gen.v
/*
 * Effective-to-linear address former of the operating mode control block.
 * Purely combinational; the caller registers the results. Assumes a
 * one-hot mode vector from the same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cmc_map.vh"

module cmc_addr_gen
(
    input  wire [5:0]  mode,
    input  wire [15:0] seg_sel,
    input  wire [31:0] seg_base,
    input  wire [63:0] eff_addr,
    output reg  [63:0] lin_addr,
    output reg         over_limit
);

    // ****************************************************************
    // Address sums
    // ****************************************************************
    wire [19:0] real_base = {seg_sel, 4'h0};
    wire [19:0] real_sum  = real_base + {4'h0, eff_addr[15:0]};
    wire [31:0] fw_sum    = {12'h000, real_base} + eff_addr[31:0];
    wire [31:0] prot_sum  = seg_base + eff_addr[31:0];

    always @*
    begin
        lin_addr   = 64'h0000000000000000;
        over_limit = 1'b0;
        if (mode[`CMC_M_LONG64])
        begin
            // Base taken as zero and no limit check: flat space.
            lin_addr = eff_addr;
        end
        else if (mode[`CMC_M_COMPAT])
        begin
            lin_addr   = {32'h00000000, prot_sum};
            over_limit = |eff_addr[63:32];
        end
        else if (mode[`CMC_M_PROT])
        begin
            // With paging off this value is used as the physical address.
            lin_addr   = {32'h00000000, prot_sum};
            over_limit = |eff_addr[63:32];
        end
        else if (mode[`CMC_M_FWSVC])
        begin
            lin_addr   = {32'h00000000, fw_sum};
            over_limit = |eff_addr[63:32];
        end
        else
        begin
            // Real and emulation modes: 1 Mbyte reach, the 20-bit sum wraps.
            lin_addr   = {44'h00000000000, real_sum};
            over_limit = |eff_addr[63:16];
        end
    end

endmodule // cmc_addr_gen

`default_nettype wire

// >>> hw/cmc_mode_ctrl.v
/*
 * Processor operating mode control: tracks the current operating mode,
 * derives per-mode sizes, privilege, register extension availability and
 * address reach, and guards entry and exit of each mode.
 * Assumes the core pipeline drives its event pulses and segment attributes
 * on core_clk; only the firmware service interrupt is an asynchronous pin.
 */
// Decided for this implementation: the address map and strobed register access.
// Overview of operation
// - Reset or power-up starts the processor in real-address mode.
// - 64-bit submode defaults to 64-bit addresses and 32-bit operands.
// - In 64-bit submode, prefixes override sizes; extension prefix widens.
// - Compatibility submode confines applications to the low 4 Gbytes.
// - Compatibility submode size prefixes toggle between 16-bit and 32-bit.
// - Long mode picks 64-bit or compatibility per code segment attribute.
// - Long mode needs paged protected operation; real mode unavailable then.
// - With long mode enabled, entering emulation mode is silently ignored.
// - Emulation flag changes only on task switch load or privileged return.
// - The flags-pop instruction never changes the emulation flag.
// - Real mode: 1 Mbyte, 16-bit default operands, no paging, level zero.
// - Protected mode: 4 Gbyte spaces, 16/32-bit operands, segment features.
// - Protected mode without paging uses virtual address as physical.
// - Protected mode supports privilege levels zero through three.
// - Emulation: level three, 1 Mbyte, real translation, 16-bit default.
// - Firmware service interrupt enters service mode with a separate space.
// - A dedicated output isolates service memory while in that mode.
// - Service mode: real addressing, 4 Gbyte limits, 16-bit defaults.
// - Extensions only in 64-bit submode; elsewhere registers are 32 bits.
// - 64-bit submode treats segment bases as zero and ignores limits.
// - Real mode base is selector shifted left four into 20 bits.
`timescale 1ns/1ns
`default_nettype none
`include "cmc_map.vh"

module cmc_mode_ctrl
(
    input  wire        core_clk,
    input  wire        resetn,
    // Register port.
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Firmware service interrupt pin, asynchronous.
    input  wire        firmware_service_interrupt,
    // Core events, one-cycle pulses on core_clk.
    input  wire        fwsvc_resume,
    input  wire        task_flags_load,
    input  wire        interrupt_return_exec,
    input  wire        emulation_mode_flag_in,
    // Current code segment attributes and prefixes of the instruction.
    input  wire        cs_long_attr,
    input  wire        cs_default_big,
    input  wire [1:0]  cs_priv,
    input  wire        pfx_opsize,
    input  wire        pfx_addrsize,
    input  wire        register_extension_prefix,
    input  wire        rex_wide,
    // Address inputs.
    input  wire [15:0] seg_sel,
    input  wire [31:0] seg_base,
    input  wire [63:0] eff_addr,
    // Derived per-mode outputs.
    output reg  [5:0]  mode_q,
    output reg  [1:0]  addr_size_q,
    output reg  [1:0]  oper_size_q,
    output reg  [1:0]  cur_priv_q,
    output reg         reg_ext_avail_q,
    output reg         ext_regs_sel_q,
    output reg         gr_width64_q,
    output reg         seg_xlate_q,
    output reg         paging_active_q,
    output reg         firmware_service_mode_q,
    output reg [63:0]  lin_addr_q,
    output reg         addr_over_q
);

    // ****************************************************************
    // Mode codes
    // ****************************************************************
    localparam [5:0] MODE_REAL   = 6'h01 << `CMC_M_REAL;
    localparam [5:0] MODE_PROT   = 6'h01 << `CMC_M_PROT;
    localparam [5:0] MODE_EMUL   = 6'h01 << `CMC_M_EMUL;
    localparam [5:0] MODE_FWSVC  = 6'h01 << `CMC_M_FWSVC;
    localparam [5:0] MODE_LONG64 = 6'h01 << `CMC_M_LONG64;
    localparam [5:0] MODE_COMPAT = 6'h01 << `CMC_M_COMPAT;

    // ****************************************************************
    // State
    // ****************************************************************
    reg  [2:0]  ctrl_q;
    reg         long_active_q;
    reg         emul_flag_q;
    reg         fwsvc_q;
    reg         fsi_meta_q;
    reg         fsi_sync_q;
    reg         fsi_prev_q;
    reg  [5:0]  mode_d;
    reg  [1:0]  addr_size_d;
    reg  [1:0]  oper_size_d;
    reg  [1:0]  cur_priv_d;
    reg  [31:0] rdata_d;
    wire [63:0] lin_addr_d;
    wire        addr_over_d;

    wire prot_en = ctrl_q[`CMC_CTRL_PROT_EN];
    wire page_en = ctrl_q[`CMC_CTRL_PAGE_EN];
    wire long_en = ctrl_q[`CMC_CTRL_LONG_EN];
    wire ctrl_wr = reg_wr && (reg_addr == `CMC_OFS_CTRL);
    wire fsi_rise = fsi_sync_q && !fsi_prev_q;

    // ****************************************************************
    // Firmware service interrupt synchroniser
    // ****************************************************************
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fsi_meta_q <= 1'b0;
            fsi_sync_q <= 1'b0;
            fsi_prev_q <= 1'b0;
        end
        else
        begin
            fsi_meta_q <= firmware_service_interrupt;
            fsi_sync_q <= fsi_meta_q;
            fsi_prev_q <= fsi_sync_q;
        end
    end

    // ****************************************************************
    // Control register and long mode activation
    // ****************************************************************
    reg [2:0] ctrl_d;
    always @*
    begin
        ctrl_d = ctrl_q;
        if (ctrl_wr)
        begin
            ctrl_d = reg_wdata[2:0];
            // Leaving protection while long mode runs would reach real
            // mode, which long mode cannot host, so the clear is dropped.
            if (long_active_q)
            begin
                ctrl_d[`CMC_CTRL_PROT_EN] = 1'b1;
            end
            // Paging without protection is meaningless; it is refused.
            if (!ctrl_d[`CMC_CTRL_PROT_EN])
            begin
                ctrl_d[`CMC_CTRL_PAGE_EN] = 1'b0;
            end
        end
    end

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q        <= `CMC_CTRL_RESET;
            long_active_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            // Activation needs protection and paging on in the same control value, which one write may set together.
            long_active_q <= ctrl_d[`CMC_CTRL_LONG_EN]
                           & ctrl_d[`CMC_CTRL_PAGE_EN]
                           & ctrl_d[`CMC_CTRL_PROT_EN];
        end
    end

    // ****************************************************************
    // Emulation flag and firmware service state
    // ****************************************************************
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            emul_flag_q <= 1'b0;
            fwsvc_q     <= 1'b0;
        end
        else
        begin
            // Only a task switch load or a level-zero return touches the
            // flag; a flags-pop has no path here at all.
            if (task_flags_load ||
                (interrupt_return_exec && cur_priv_q == 2'h0))
            begin
                emul_flag_q <= emulation_mode_flag_in && !long_en;
            end
            if (fsi_rise)
            begin
                fwsvc_q <= 1'b1;
            end
            else if (fwsvc_resume)
            begin
                fwsvc_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Mode derivation
    // ****************************************************************
    always @*
    begin
        if (fwsvc_q)
        begin
            mode_d = MODE_FWSVC;
        end
        else if (!prot_en)
        begin
            mode_d = MODE_REAL;
        end
        else if (long_active_q)
        begin
            mode_d = cs_long_attr ? MODE_LONG64 : MODE_COMPAT;
        end
        else if (emul_flag_q)
        begin
            mode_d = MODE_EMUL;
        end
        else
        begin
            mode_d = MODE_PROT;
        end
    end

    // ****************************************************************
    // Per-mode sizes and privilege
    // ****************************************************************
    always @*
    begin
        case (mode_d)
            MODE_LONG64:
            begin
                addr_size_d = pfx_addrsize ? `CMC_SZ_32 : `CMC_SZ_64;
                if (register_extension_prefix && rex_wide)
                begin
                    oper_size_d = `CMC_SZ_64;
                end
                else if (pfx_opsize)
                begin
                    oper_size_d = `CMC_SZ_16;
                end
                else
                begin
                    oper_size_d = `CMC_SZ_32;
                end
                cur_priv_d = cs_priv;
            end
            MODE_COMPAT, MODE_PROT:
            begin
                addr_size_d = (cs_default_big ^ pfx_addrsize) ?
                              `CMC_SZ_32 : `CMC_SZ_16;
                oper_size_d = (cs_default_big ^ pfx_opsize) ?
                              `CMC_SZ_32 : `CMC_SZ_16;
                cur_priv_d  = cs_priv;
            end
            MODE_EMUL:
            begin
                addr_size_d = pfx_addrsize ? `CMC_SZ_32 : `CMC_SZ_16;
                oper_size_d = pfx_opsize ? `CMC_SZ_32 : `CMC_SZ_16;
                cur_priv_d  = 2'h3;
            end
            MODE_FWSVC:
            begin
                addr_size_d = pfx_addrsize ? `CMC_SZ_32 : `CMC_SZ_16;
                oper_size_d = pfx_opsize ? `CMC_SZ_32 : `CMC_SZ_16;
                cur_priv_d  = 2'h0;
            end
            default:
            begin
                addr_size_d = pfx_addrsize ? `CMC_SZ_32 : `CMC_SZ_16;
                oper_size_d = pfx_opsize ? `CMC_SZ_32 : `CMC_SZ_16;
                cur_priv_d  = 2'h0;
            end
        endcase
    end

    // ****************************************************************
    // Address forming
    // ****************************************************************
    cmc_addr_gen u_addr_gen
    (
        .mode       (mode_d),
        .seg_sel    (seg_sel),
        .seg_base   (seg_base),
        .eff_addr   (eff_addr),
        .lin_addr   (lin_addr_d),
        .over_limit (addr_over_d)
    );

    // ****************************************************************
    // Register read mux
    // ****************************************************************
    always @*
    begin
        rdata_d = 32'h00000000;
        if (reg_rd)
        begin
            case (reg_addr)
                `CMC_OFS_CTRL:
                begin
                    rdata_d = {29'h00000000, ctrl_q};
                end
                `CMC_OFS_STATUS:
                begin
                    rdata_d = {22'h000000, emul_flag_q, long_active_q,
                               2'h0, mode_q};
                end
                `CMC_OFS_SIZES:
                begin
                    rdata_d = {26'h0000000, cur_priv_q, oper_size_q,
                               addr_size_q};
                end
                default:
                begin
                    rdata_d = 32'h00000000;
                end
            endcase
        end
    end

    // ****************************************************************
    // Output registers
    // ****************************************************************
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q                  <= MODE_REAL;
            addr_size_q             <= `CMC_SZ_16;
            oper_size_q             <= `CMC_SZ_16;
            cur_priv_q              <= 2'h0;
            reg_ext_avail_q         <= 1'b0;
            ext_regs_sel_q          <= 1'b0;
            gr_width64_q            <= 1'b0;
            seg_xlate_q             <= 1'b0;
            paging_active_q         <= 1'b0;
            firmware_service_mode_q <= 1'b0;
            lin_addr_q              <= 64'h0000000000000000;
            addr_over_q             <= 1'b0;
            reg_rdata               <= 32'h00000000;
        end
        else
        begin
            mode_q          <= mode_d;
            addr_size_q     <= addr_size_d;
            oper_size_q     <= oper_size_d;
            cur_priv_q      <= cur_priv_d;
            reg_ext_avail_q <= mode_d[`CMC_M_LONG64];
            ext_regs_sel_q  <= mode_d[`CMC_M_LONG64]
                             & register_extension_prefix;
            gr_width64_q    <= mode_d[`CMC_M_LONG64];
            seg_xlate_q     <= mode_d[`CMC_M_PROT]
                             | mode_d[`CMC_M_COMPAT];
            paging_active_q <= page_en & ~mode_d[`CMC_M_REAL]
                             & ~mode_d[`CMC_M_FWSVC];
            firmware_service_mode_q <= fwsvc_q;
            lin_addr_q      <= lin_addr_d;
            addr_over_q     <= addr_over_d;
            reg_rdata       <= rdata_d;
        end
    end

endmodule // cmc_mode_ctrl

`default_nettype wire

// >>> test/cmc_mode_sva.sv
/* Concurrent checks on the ports of the mode control block.
   Assumes one clock, core_clk, and the async active-low resetn. */
`timescale 1ns/1ns
`default_nettype none

module cmc_mode_sva
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        firmware_service_interrupt,
    input wire logic        pfx_opsize,
    input wire logic        pfx_addrsize,
    input wire logic        register_extension_prefix,
    input wire logic        rex_wide,
    input wire logic        cs_default_big,
    input wire logic [15:0] seg_sel,
    input wire logic [63:0] eff_addr,
    input wire logic [5:0]  mode_q,
    input wire logic [1:0]  addr_size_q,
    input wire logic [1:0]  oper_size_q,
    input wire logic [1:0]  cur_priv_q,
    input wire logic        reg_ext_avail_q,
    input wire logic        gr_width64_q,
    input wire logic        paging_active_q,
    input wire logic        firmware_service_mode_q,
    input wire logic [63:0] lin_addr_q,
    input wire logic        addr_over_q
);
    // ********
    // Helpers
    // ********
    // Outputs lag inputs by one edge, so address sums are taken via $past.
    wire        hi_nz    = eff_addr[63:32] != 32'h0;
    wire [19:0] real_lin = {seg_sel, 4'h0} + {4'h0, eff_addr[15:0]};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_mode_onehot: assert property ($onehot(mode_q))
        else $error("mode vector not one-hot");
    chk_ext_only64: assert property (reg_ext_avail_q == mode_q[4] &&
        gr_width64_q == mode_q[4]) else $error("extension flags wrong");
    chk_fw_isolate: assert property (
        firmware_service_mode_q == mode_q[3])
        else $error("isolation output wrong");
    chk_fw_entry: assert property ($rose(firmware_service_interrupt)
        |-> ##[1:5] mode_q[3]) else $error("service mode not entered");
    chk_real_flat: assert property (mode_q[0] |-> cur_priv_q == 2'h0 &&
        !paging_active_q) else $error("real mode privilege or paging");
    chk_emul_priv: assert property (mode_q[2] |-> cur_priv_q == 2'h3)
        else $error("emulation privilege wrong");
    chk_long_size: assert property ($past(resetn) && mode_q[4] &&
        !$past(pfx_opsize) && !$past(pfx_addrsize) &&
        !$past(register_extension_prefix) |-> addr_size_q == 2'h2 &&
        oper_size_q == 2'h1) else $error("64-bit default sizes wrong");
    chk_wide_oper: assert property ($past(resetn) && mode_q[4] &&
        $past(register_extension_prefix) && $past(rex_wide) |->
        oper_size_q == 2'h2) else $error("wide operand not selected");
    chk_compat_size: assert property ($past(resetn) && mode_q[5] |->
        oper_size_q == {1'b0, $past(cs_default_big) ^ $past(pfx_opsize)})
        else $error("compatibility operand size wrong");
    chk_compat_reach: assert property ($past(resetn) && mode_q[5] |->
        addr_over_q == $past(hi_nz)) else $error("reach flag wrong");
    chk_flat_64: assert property ($past(resetn) && mode_q[4] |->
        lin_addr_q == $past(eff_addr) && !addr_over_q)
        else $error("64-bit address not flat");
    chk_real_base: assert property ($past(resetn) && mode_q[0] |->
        lin_addr_q[19:0] == $past(real_lin)) else $error("real address wrong");

    cover property (mode_q[4] && oper_size_q == 2'h2);
    cover property (mode_q[2]);
    cover property (firmware_service_mode_q);
    cover property (mode_q[5] && addr_over_q);
endmodule // cmc_mode_sva

bind cmc_mode_ctrl cmc_mode_sva u_sva
(
    .core_clk, .resetn, .firmware_service_interrupt, .pfx_opsize,
    .pfx_addrsize, .register_extension_prefix, .rex_wide, .cs_default_big,
    .seg_sel, .eff_addr, .mode_q, .addr_size_q, .oper_size_q, .cur_priv_q,
    .reg_ext_avail_q, .gr_width64_q, .paging_active_q,
    .firmware_service_mode_q, .lin_addr_q, .addr_over_q
);
`default_nettype wire

// >>> test/testbench.sv
/* Self-checking bench of the mode control block: a table of mode rows,
   then service mode, reset and emulation flag cases. Assumes core_clk. */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    typedef struct packed
    {
        logic [2:0] c;
        logic [7:0] p;
        logic [1:0] e;
        logic [5:0] m;
        logic [1:0] a;
        logic [1:0] o;
        logic [1:0] v;
    } cmc_row_t;

    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        firmware_service_interrupt = 1'b0;
    logic        emulation_mode_flag_in = 1'b0;
    logic [2:0]  ev = 3'h0;
    logic [7:0]  pn = 8'h00;
    logic [15:0] seg_sel = 16'h1234;
    logic [31:0] seg_base = 32'h10000;
    logic [63:0] eff_addr = 64'h0;
    logic [31:0] reg_rdata;
    logic [5:0]  mode_q;
    logic [1:0]  addr_size_q, oper_size_q, cur_priv_q;
    logic        reg_ext_avail_q, ext_regs_sel_q, gr_width64_q;
    logic        seg_xlate_q, paging_active_q, firmware_service_mode_q;
    logic        addr_over_q;
    logic [63:0] lin_addr_q;
    integer      errors = 0;
    integer      checked = 0;
    logic [31:0] d;
    cmc_row_t    r;
    logic [63:0] eas [0:2] = '{64'hABCD, 64'h10000, 64'h100000000};
    // Pin bits: long attr, big, op prefix, addr prefix, ext, wide, priv.
    cmc_row_t    rows [0:11] = '{
        '{3'h0, 8'h03, 2'h0, 6'h01, 2'h0, 2'h0, 2'h0},
        '{3'h0, 8'h20, 2'h1, 6'h01, 2'h0, 2'h1, 2'h0},
        '{3'h1, 8'h42, 2'h0, 6'h02, 2'h1, 2'h1, 2'h2},
        '{3'h1, 8'h03, 2'h2, 6'h02, 2'h0, 2'h0, 2'h3},
        '{3'h3, 8'h70, 2'h0, 6'h02, 2'h0, 2'h0, 2'h0},
        '{3'h7, 8'h80, 2'h2, 6'h10, 2'h2, 2'h1, 2'h0},
        '{3'h7, 8'hA0, 2'h0, 6'h10, 2'h2, 2'h0, 2'h0},
        '{3'h7, 8'h8C, 2'h0, 6'h10, 2'h2, 2'h2, 2'h0},
        '{3'h7, 8'hAC, 2'h0, 6'h10, 2'h2, 2'h2, 2'h0},
        '{3'h7, 8'h90, 2'h0, 6'h10, 2'h1, 2'h1, 2'h0},
        '{3'h7, 8'h43, 2'h2, 6'h20, 2'h1, 2'h1, 2'h3},
        '{3'h7, 8'h78, 2'h0, 6'h20, 2'h0, 2'h0, 2'h0}};

    always #50 core_clk = ~core_clk;

    cmc_mode_ctrl dut
    (
        .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .firmware_service_interrupt, .fwsvc_resume(ev[0]),
        .task_flags_load(ev[1]), .interrupt_return_exec(ev[2]),
        .emulation_mode_flag_in, .cs_long_attr(pn[7]),
        .cs_default_big(pn[6]), .cs_priv(pn[1:0]), .pfx_opsize(pn[5]),
        .pfx_addrsize(pn[4]), .register_extension_prefix(pn[3]),
        .rex_wide(pn[2]), .seg_sel, .seg_base, .eff_addr, .mode_q,
        .addr_size_q, .oper_size_q, .cur_priv_q, .reg_ext_avail_q,
        .ext_regs_sel_q, .gr_width64_q, .seg_xlate_q, .paging_active_q,
        .firmware_service_mode_q, .lin_addr_q, .addr_over_q
    );

    // ********
    // Helpers
    // ********
    // Expected {reach violation, linear address} for a one-hot mode.
    function automatic logic [64:0] ex(input logic [5:0] m,
                                       input logic [63:0] a);
        if (m[4])
            ex = {1'b0, a};
        else if (m[1] | m[5])
            ex = {a[63:32] != 32'h0, 32'h0, seg_base + a[31:0]};
        else if (m[3])
            ex = {1'b0, 32'h0, {12'h0, seg_sel, 4'h0} + a[31:0]};
        else
            ex = {a[63:16] != 48'h0, 44'h0, {seg_sel, 4'h0} + {4'h0, a[15:0]}};
    endfunction

    task chk(input logic [64:0] s, input logic [64:0] e);
        checked = checked + 1;
        if (s !== e)
        begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task pulse(input logic [2:0] k, input logic f);
        @(posedge core_clk);
        ev <= k;
        emulation_mode_flag_in <= f;
        @(posedge core_clk);
        ev <= 3'h0;
        settle;
    endtask

    task summarize;
        $display("checked %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #1000000;
        errors = errors + 1;
        summarize;
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        settle;
        chk(mode_q, 6'h01);
        // Rows climb real, protected, paged, long: protection comes first.
        for (int i = 0; i < 12; i++)
        begin
            r = rows[i];
            @(posedge core_clk);
            pn <= r.p;
            eff_addr <= eas[r.e];
            wr(4'h0, {29'h0, r.c});
            settle;
            chk(mode_q, r.m);
            chk({cur_priv_q, oper_size_q, addr_size_q},
                {r.v, r.o, r.a});
            chk({reg_ext_avail_q, gr_width64_q, ext_regs_sel_q},
                {r.m[4], r.m[4], r.m[4] & r.p[3]});
            chk({seg_xlate_q, paging_active_q},
                {r.m[1] | r.m[5], r.c[1] & ~r.m[0]});
            chk({addr_over_q, lin_addr_q}, ex(r.m, eff_addr));
            rd(4'h4);
            chk(d, {22'h0, 1'b0, r.c == 3'h7, 2'h0, r.m});
            rd(4'h8);
            chk(d, {26'h0, r.v, r.o, r.a});
            rd(4'h0);
            chk(d, {29'h0, r.c});
        end
        @(posedge core_clk);
        pn <= 8'h00;
        eff_addr <= eas[0];
        firmware_service_interrupt <= 1'b1;
        for (int n = 0; n < 10 && firmware_service_mode_q !== 1'b1; n++)
            @(posedge core_clk);
        #1;
        chk(firmware_service_mode_q, 1'b1);
        chk(mode_q, 6'h08);
        chk({cur_priv_q, oper_size_q, addr_size_q}, 6'h00);
        chk(lin_addr_q, ex(6'h08, eff_addr));
        @(posedge core_clk);
        firmware_service_interrupt <= 1'b0;
        pulse(3'h1, 1'b0);
        chk({firmware_service_mode_q, mode_q}, 7'h20);
        pulse(3'h2, 1'b1);
        rd(4'h4);
        chk({mode_q, d[9]}, 7'h40);
        // Unmapped read gives zero; a write to status is dropped.
        rd(4'hC);
        chk(d, 32'h0);
        wr(4'h4, 32'h0);
        rd(4'h0);
        chk(d, 32'h7);
        wr(4'h0, 32'h0);
        settle;
        chk(mode_q[0], 1'b0);
        @(posedge core_clk);
        resetn <= 1'b0;
        #1 chk(mode_q, 6'h01);
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        pn <= 8'h40;
        eff_addr <= eas[1];
        wr(4'h0, 32'h1);
        @(posedge core_clk);
        emulation_mode_flag_in <= 1'b1;
        settle;
        chk(mode_q, 6'h02);
        pulse(3'h4, 1'b1);
        chk({mode_q, cur_priv_q, oper_size_q}, 10'h04C);
        chk({addr_over_q, lin_addr_q}, ex(6'h04, eff_addr));
        pulse(3'h4, 1'b0);
        chk(mode_q, 6'h04);
        pulse(3'h2, 1'b0);
        chk(mode_q, 6'h02);
        @(posedge core_clk);
        pn <= 8'h43;
        pulse(3'h4, 1'b1);
        chk(mode_q, 6'h02);
        pulse(3'h2, 1'b1);
        chk(mode_q, 6'h04);
        summarize;
    end
endmodule // testbench
`default_nettype wire
